// ### logic/sync_clamp_hold_control.sv
`timescale 1ns/1ps
`include "sync_ctl_defs.svh"
// Contract
// - output polarity bit sets line and green sync
// - line override clear means automatic line choice
// - line select picks pin or green sync
// - frame invert bit: 0 inverts, 1 passes
// - frame override clear means automatic frame choice
// - frame select picks pin or separator
// - clamp source internal timing or external pin
// - external clamp clamps all three channels
// - clamp polarity 1 clamps while pin low
// - hold source is hold pin or frame sync
// - hold polarity detected unless override set
// - active hold makes generator ignore line sync
// - seek permit allows low power without sync
// - sleep request bit 0 powers down
// - power-down floats line and frame sync, clock, data outputs
// - sync logic and serial port stay alive
// - five-bit slicer threshold, default fifteen
// - red clamp reference ground or midscale
// - blue clamp reference ground or midscale
// - separator counts threshold ticks before toggling
// - automatic line choice follows detected sources
// - automatic frame choice prefers detected pin
// - internal clamp placement then duration

module sync_clamp_hold_control (
  input  wire logic                  core_clk,
  input  wire logic                  nrst,
  input  wire logic                  scl,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe,
  input  wire sync_ctl_pkg::sync_in_s sync_in,
  input  wire logic                  pixel_tick,
  input  wire logic [7:0]            clamp_placement,
  input  wire logic [7:0]            clamp_duration,
  output sync_ctl_pkg::sync_out_s    sync_out,
  output logic                       line_sync_output_oe,
  output logic                       frame_sync_output_oe,
  output logic                       sample_clock_output_oe,
  output logic                       pixel_data_oe,
  output logic [4:0]                 slicer_threshold,
  output logic                       red_midscale,
  output logic                       blue_midscale
);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [7:0] cfg_q [4];

  function automatic logic [1:0] reg_index(input logic [7:0] ofs);
    return 2'(ofs - `OFS_SYNC_SELECT_POLARITY);
  endfunction

  function automatic logic reg_hit(input logic [7:0] ofs);
    return (ofs >= `OFS_SYNC_SELECT_POLARITY) && (ofs <= `OFS_SEPARATOR_THRESHOLD);
  endfunction

  wire [7:0] sel_pol = cfg_q[0];
  wire [7:0] chp_ctl = cfg_q[1];
  wire [7:0] slc_ref = cfg_q[2];
  wire [7:0] sep_thr = cfg_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // two-wire serial port, alive in power-down

  sync_ctl_pkg::ser_state_e state_q;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bits_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic       rw_q;
  logic       nack_q;
  logic       drive_q;

  wire scl_rise  = scl && !scl_q;
  wire scl_fall  = !scl && scl_q;
  wire bus_start = scl && scl_q && sda_q && !sda_in;
  wire bus_stop  = scl && scl_q && !sda_q && sda_in;
  wire byte_done = (bits_q == 4'd8);
  wire addr_ok   = (shift_q[7:1] == `SERIAL_DEV_ADDR);
  wire wr_hit    = reg_hit(ptr_q);
  wire [1:0] wr_idx = reg_index(ptr_q);
  wire [7:0] rd_data = wr_hit ? cfg_q[wr_idx] : 8'h00;
  wire [7:0] ptr_next = ptr_q + 8'h01;
  wire [7:0] rd_next = reg_hit(ptr_next) ? cfg_q[reg_index(ptr_next)] : 8'h00;
  wire do_write  = (state_q == sync_ctl_pkg::SER_WR) && scl_fall && byte_done;
  // ack bit is not a data bit: restart the count after it
  wire ack_phase = state_q inside {sync_ctl_pkg::SER_ACK_A, sync_ctl_pkg::SER_ACK_P,
                                   sync_ctl_pkg::SER_ACK_W, sync_ctl_pkg::SER_ACK_R};

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // bit counter and shift register
  always_ff @(posedge core_clk) begin
    if (!nrst || bus_start) begin
      bits_q  <= '0;
      shift_q <= '0;
    end else if (scl_rise && state_q != sync_ctl_pkg::SER_RD) begin
      bits_q  <= byte_done ? 4'd1 : bits_q + 4'd1;
      shift_q <= {shift_q[6:0], sda_in};
    end else if (scl_rise) begin
      bits_q <= byte_done ? 4'd1 : bits_q + 4'd1;
    end else if (scl_fall && state_q == sync_ctl_pkg::SER_ACK_A && rw_q) begin
      bits_q  <= '0;
      shift_q <= rd_data;
    end else if (scl_fall && state_q == sync_ctl_pkg::SER_ACK_R && !nack_q) begin
      bits_q  <= '0;
      shift_q <= rd_next;
    end else if (scl_fall && state_q == sync_ctl_pkg::SER_RD && !byte_done) begin
      shift_q <= {shift_q[6:0], 1'b0};
    end else if (scl_fall && (byte_done || ack_phase)) begin
      bits_q <= '0;
    end
  end

  // protocol state machine
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_q <= sync_ctl_pkg::SER_IDLE;
      drive_q <= 1'b0;
      rw_q    <= 1'b0;
      ptr_q   <= '0;
      nack_q  <= 1'b0;
    end else if (bus_start) begin
      state_q <= sync_ctl_pkg::SER_ADDR;
      drive_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= sync_ctl_pkg::SER_IDLE;
      drive_q <= 1'b0;
    end else if (scl_rise && state_q == sync_ctl_pkg::SER_ACK_R) begin
      nack_q <= sda_in;
    end else if (scl_fall) begin
      unique case (state_q)
        sync_ctl_pkg::SER_IDLE: begin
          drive_q <= 1'b0;
        end
        sync_ctl_pkg::SER_ADDR: begin
          if (byte_done) begin
            state_q <= addr_ok ? sync_ctl_pkg::SER_ACK_A : sync_ctl_pkg::SER_IDLE;
            drive_q <= addr_ok;
            rw_q    <= shift_q[0];
          end
        end
        sync_ctl_pkg::SER_ACK_A: begin
          state_q <= rw_q ? sync_ctl_pkg::SER_RD : sync_ctl_pkg::SER_PTR;
          drive_q <= rw_q && !rd_data[7];
        end
        sync_ctl_pkg::SER_PTR: begin
          if (byte_done) begin
            ptr_q   <= shift_q;
            state_q <= sync_ctl_pkg::SER_ACK_P;
            drive_q <= 1'b1;
          end
        end
        sync_ctl_pkg::SER_ACK_P: begin
          state_q <= sync_ctl_pkg::SER_WR;
          drive_q <= 1'b0;
        end
        sync_ctl_pkg::SER_WR: begin
          if (byte_done) begin
            state_q <= sync_ctl_pkg::SER_ACK_W;
            drive_q <= 1'b1;
          end
        end
        sync_ctl_pkg::SER_ACK_W: begin
          ptr_q   <= ptr_next;
          state_q <= sync_ctl_pkg::SER_WR;
          drive_q <= 1'b0;
        end
        sync_ctl_pkg::SER_RD: begin
          if (byte_done) begin
            state_q <= sync_ctl_pkg::SER_ACK_R;
            drive_q <= 1'b0;
          end else begin
            drive_q <= !shift_q[6];
          end
        end
        sync_ctl_pkg::SER_ACK_R: begin
          if (nack_q) begin
            state_q <= sync_ctl_pkg::SER_IDLE;
            drive_q <= 1'b0;
          end else begin
            ptr_q   <= ptr_next;
            state_q <= sync_ctl_pkg::SER_RD;
            drive_q <= !rd_next[7];
          end
        end
        default: begin
          state_q <= sync_ctl_pkg::SER_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_q;

  // defaults on reset, then serial writes
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cfg_q[0] <= `RST_SYNC_SELECT_POLARITY;
      cfg_q[1] <= `RST_CLAMP_HOLD_POWER_CONTROL;
      cfg_q[2] <= `RST_SLICER_AND_CLAMP_REF;
      cfg_q[3] <= `RST_SEPARATOR_THRESHOLD;
    end else if (do_write && wr_hit) begin
      cfg_q[wr_idx] <= shift_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line sync selection

  wire line_ovr = sel_pol[`B_LINE_OVERRIDE];
  wire line_sel = sel_pol[`B_LINE_SELECT];
  wire only_grn = sync_in.green_det && !sync_in.line_det;
  wire only_pin = sync_in.line_det && !sync_in.green_det;
  wire auto_line = only_grn ? 1'b1 : (only_pin ? 1'b0 : line_sel);
  wire act_line  = line_ovr ? line_sel : auto_line;
  wire line_raw  = act_line ? sync_in.green : sync_in.line_pin;
  wire line_norm = line_raw ^ !sel_pol[`B_LINE_IN_POL];
  wire out_pol   = sel_pol[`B_OUT_POL];

  ////////////////////////////////////////////////////////////////////////////
  // frame sync selection and separator

  wire sep_frame;

  sync_separator u_sep (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .sync_in   (line_norm),
    .threshold (sep_thr),
    .frame_out (sep_frame)
  );

  wire frame_ovr = sel_pol[`B_FRAME_OVERRIDE];
  wire act_frame = frame_ovr ? sel_pol[`B_FRAME_SELECT] : !sync_in.frame_det;
  wire frame_raw = act_frame ? sep_frame : sync_in.frame_pin;

  ////////////////////////////////////////////////////////////////////////////
  // clamp

  wire int_clamp;

  clamp_timer u_clamp (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .line_sync  (line_norm),
    .pixel_tick (pixel_tick),
    .placement  (clamp_placement),
    .duration   (clamp_duration),
    .clamp      (int_clamp)
  );

  wire ext_clamp = chp_ctl[`B_CLAMP_POL] ? !sync_in.clamp_pin : sync_in.clamp_pin;
  wire clamp_now = chp_ctl[`B_CLAMP_EXTERNAL] ? ext_clamp : int_clamp;

  ////////////////////////////////////////////////////////////////////////////
  // pll hold, seek, power-down

  wire hold_src = chp_ctl[`B_HOLD_SOURCE] ? frame_raw : sync_in.hold_pin;
  wire hold_pol = chp_ctl[`B_HOLD_POL_OVERRIDE] ? chp_ctl[`B_HOLD_POL]
                                                : sync_in.hold_pol_det;
  wire hold_now = hold_pol ? hold_src : !hold_src;
  wire no_sync  = !(sync_in.line_det || sync_in.green_det || sync_in.frame_det);
  wire seek_now = chp_ctl[`B_SEEK_PERMIT] && no_sync;
  wire sleep    = !chp_ctl[`B_SLEEP_REQUEST];

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_out <= '0;
    end else begin
      sync_out.line_sync    <= line_norm ^ out_pol;
      sync_out.green_sync   <= sync_in.green ^ out_pol;
      sync_out.frame_sync   <= frame_raw ^ !sel_pol[`B_FRAME_NO_INVERT];
      sync_out.active_line  <= act_line;
      sync_out.active_frame <= act_frame;
      sync_out.clamp        <= clamp_now;
      sync_out.hold         <= hold_now;
      sync_out.seek         <= seek_now;
      sync_out.sleep        <= sleep;
    end
  end

  // green sync output never floats
  assign line_sync_output_oe    = !sleep;
  assign frame_sync_output_oe   = !sleep;
  assign sample_clock_output_oe = !sleep;
  assign pixel_data_oe          = !sleep;

  assign slicer_threshold = slc_ref[`F_SLICER_HI:`F_SLICER_LO];
  assign red_midscale     = slc_ref[`B_RED_MIDSCALE];
  assign blue_midscale    = slc_ref[`B_BLUE_MIDSCALE];

endmodule

// ### logic/sync_ctl_defs.svh
`ifndef SYNC_CTL_DEFS_SVH
`define SYNC_CTL_DEFS_SVH

// register offsets
`define OFS_SYNC_SELECT_POLARITY      8'h0E
`define OFS_CLAMP_HOLD_POWER_CONTROL  8'h0F
`define OFS_SLICER_AND_CLAMP_REF      8'h10
`define OFS_SEPARATOR_THRESHOLD       8'h11

// reset values
`define RST_SYNC_SELECT_POLARITY      8'h40
`define RST_CLAMP_HOLD_POWER_CONTROL  8'h4E
`define RST_SLICER_AND_CLAMP_REF      8'h78
`define RST_SEPARATOR_THRESHOLD       8'h20

// sync_select_polarity fields
`define B_LINE_IN_POL                 6
`define B_OUT_POL                     5
`define B_LINE_OVERRIDE               4
`define B_LINE_SELECT                 3
`define B_FRAME_NO_INVERT             2
`define B_FRAME_OVERRIDE              1
`define B_FRAME_SELECT                0

// clamp_hold_power_control fields
`define B_CLAMP_EXTERNAL              7
`define B_CLAMP_POL                   6
`define B_HOLD_SOURCE                 5
`define B_HOLD_POL_OVERRIDE           4
`define B_HOLD_POL                    3
`define B_SEEK_PERMIT                 2
`define B_SLEEP_REQUEST               1

// slicer_and_clamp_reference fields
`define F_SLICER_HI                   7
`define F_SLICER_LO                   3
`define B_RED_MIDSCALE                2
`define B_BLUE_MIDSCALE               1

// timing
`define CORE_CLK_MHZ                  250
`define SEP_CLK_MHZ                   5
`define SEP_TICK_CYCLES               (`CORE_CLK_MHZ / `SEP_CLK_MHZ)

// serial port
`define SERIAL_DEV_ADDR               7'h4C

`endif

// ### logic/sync_ctl_pkg.sv
package sync_ctl_pkg;

  typedef struct packed {
    logic line_pin;
    logic green;
    logic frame_pin;
    logic line_det;
    logic green_det;
    logic frame_det;
    logic clamp_pin;
    logic hold_pin;
    logic hold_pol_det;
  } sync_in_s;

  typedef struct packed {
    logic line_sync;
    logic green_sync;
    logic frame_sync;
    logic active_line;
    logic active_frame;
    logic clamp;
    logic hold;
    logic seek;
    logic sleep;
  } sync_out_s;

  typedef enum logic [3:0] {
    SER_IDLE  = 4'b0000,
    SER_ADDR  = 4'b0001,
    SER_ACK_A = 4'b0011,
    SER_PTR   = 4'b0010,
    SER_ACK_P = 4'b0110,
    SER_WR    = 4'b0111,
    SER_ACK_W = 4'b0101,
    SER_RD    = 4'b0100,
    SER_ACK_R = 4'b1100
  } ser_state_e;

endpackage

// ### logic/sync_separator.sv
`timescale 1ns/1ps
`include "sync_ctl_defs.svh"

module sync_separator (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       sync_in,
  input  wire logic [7:0] threshold,
  output logic            frame_out
);

  localparam int TICK_N = `SEP_TICK_CYCLES;

  logic [5:0] div_q;
  logic [7:0] cnt_q;
  logic       out_q;
  wire        tick   = (div_q == 6'(TICK_N - 1));
  wire        differ = (sync_in != out_q);
  wire        reach  = tick && differ && (cnt_q + 8'h01 >= threshold);

  // about 5 MHz count tick from the core clock
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      div_q <= '0;
    end else begin
      div_q <= tick ? 6'h00 : div_q + 6'h01;
    end
  end

  // level must persist threshold ticks before output follows
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else if (!differ) begin
      cnt_q <= '0;
    end else if (reach) begin
      cnt_q <= '0;
      out_q <= ~out_q;
    end else if (tick && cnt_q != 8'hFF) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign frame_out = out_q;

endmodule

// ### logic/clamp_timer.sv
`timescale 1ns/1ps

module clamp_timer (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       line_sync,
  input  wire logic       pixel_tick,
  input  wire logic [7:0] placement,
  input  wire logic [7:0] duration,
  output logic            clamp
);

  logic       sync_q;
  logic       wait_q;
  logic       on_q;
  logic [7:0] cnt_q;
  wire        trail = sync_q && !line_sync;

  // placement then duration, both in pixel periods
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync_q <= 1'b0;
      wait_q <= 1'b0;
      on_q   <= 1'b0;
      cnt_q  <= '0;
    end else begin
      sync_q <= line_sync;
      if (trail) begin
        wait_q <= 1'b1;
        on_q   <= 1'b0;
        cnt_q  <= placement;
      end else if (pixel_tick && (wait_q || on_q)) begin
        if (cnt_q > 8'h01) begin
          cnt_q <= cnt_q - 8'h01;
        end else if (wait_q) begin
          wait_q <= 1'b0;
          on_q   <= 1'b1;
          cnt_q  <= duration;
        end else begin
          on_q <= 1'b0;
        end
      end
    end
  end

  assign clamp = on_q;

endmodule

// ### verif/sync_ctl_monitor.sv
`timescale 1ns/1ps
module sync_ctl_monitor (
  input wire logic                    core_clk,
  input wire logic                    nrst,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  input wire sync_ctl_pkg::sync_in_s  sync_in,
  input wire sync_ctl_pkg::sync_out_s sync_out,
  input wire logic                    line_sync_output_oe,
  input wire logic                    frame_sync_output_oe,
  input wire logic                    sample_clock_output_oe,
  input wire logic                    pixel_data_oe,
  input wire logic [4:0]              slicer_threshold,
  input wire logic                    red_midscale,
  input wire logic                    blue_midscale
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // green sync keeps one polarity offset unless a byte was just taken
  property p_green_pol;
    $past(nrst) && $past(nrst, 2) && !$past(sda_oe) |->
      (sync_out.green_sync ^ $past(sync_in.green)) ==
      ($past(sync_out.green_sync) ^ $past(sync_in.green, 2));
  endproperty
  a_green_pol: assert property (p_green_pol) else $error("green sync polarity jumped");
  property p_seek;
    sync_out.seek |-> !($past(sync_in.line_det) || $past(sync_in.green_det) ||
                        $past(sync_in.frame_det));
  endproperty
  a_seek: assert property (p_seek) else $error("seek while sync present");
  property p_sleep_oe;
    $past(nrst) |-> sync_out.sleep == !$past(line_sync_output_oe);
  endproperty
  a_sleep_oe: assert property (p_sleep_oe) else $error("sleep flag and enables disagree");
  property p_oe_equal;
    line_sync_output_oe == frame_sync_output_oe &&
    sample_clock_output_oe == pixel_data_oe && pixel_data_oe == line_sync_output_oe;
  endproperty
  a_oe_equal: assert property (p_oe_equal) else $error("output enables differ");
  property p_reset_defaults;
    $rose(nrst) |-> line_sync_output_oe && slicer_threshold == 5'h0F &&
                    !red_midscale && !blue_midscale && !sda_oe;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("defaults missing");
  property p_cfg_on_ack;
    $changed({slicer_threshold, red_midscale, blue_midscale, line_sync_output_oe})
      |-> $rose(sda_oe);
  endproperty
  a_cfg_on_ack: assert property (p_cfg_on_ack) else $error("config moved without ack");
  property p_ack_hold;
    $rose(sda_oe) |-> sda_oe [*6];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda pull too short");
  property p_open_drain;
    !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("sda driven high");
endmodule

// ### verif/video_source_model.sv
`timescale 1ns/1ps
module video_source_model (
  input  wire logic              core_clk,
  input  wire logic              line_en,
  input  wire logic              green_en,
  input  wire logic              line_force,
  input  wire logic              frame_pin,
  input  wire logic              frame_det,
  input  wire logic              clamp_pin,
  input  wire logic              hold_pin,
  input  wire logic              hold_pol_det,
  output sync_ctl_pkg::sync_in_s sync_in
);
  logic [1:0] cnt_q = 2'h0;
  logic       ph_q  = 1'b0;
  // line and green run in opposite phase so the chosen one is visible
  always @(posedge core_clk) begin
    cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
    if (cnt_q == 2'h2) ph_q <= ~ph_q;
  end
  assign sync_in = {line_force | (line_en & ph_q), green_en & ~ph_q, frame_pin, line_en,
                    green_en, frame_det, clamp_pin, hold_pin, hold_pol_det};
endmodule

// ### verif/sync_clamp_hold_control_tb.sv
`timescale 1ns/1ps
`include "sync_ctl_defs.svh"
module sync_clamp_hold_control_tb;
  logic                    core_clk, nrst, scl, tb_low, pixel_tick;
  logic                    line_en, green_en, line_force, frame_pin, frame_det;
  logic                    clamp_pin, hold_pin, hold_pol_det;
  logic                    sda_out, sda_oe, l_oe, f_oe, s_oe, p_oe, red_mid, blue_mid;
  logic [7:0]              placement, duration;
  logic [4:0]              slicer;
  int                      fails, samples_checked;
  sync_ctl_pkg::sync_in_s  sin, prev;
  sync_ctl_pkg::sync_out_s sout;
  wire                     sda = !(sda_oe | tb_low);
  video_source_model u_src (.core_clk, .line_en, .green_en, .line_force, .frame_pin,
    .frame_det, .clamp_pin, .hold_pin, .hold_pol_det, .sync_in(sin));
  sync_clamp_hold_control u_dut (.core_clk, .nrst, .scl, .sda_in(sda), .sda_out, .sda_oe,
    .sync_in(sin), .pixel_tick, .clamp_placement(placement), .clamp_duration(duration),
    .sync_out(sout), .line_sync_output_oe(l_oe), .frame_sync_output_oe(f_oe),
    .sample_clock_output_oe(s_oe), .pixel_data_oe(p_oe), .slicer_threshold(slicer),
    .red_midscale(red_mid), .blue_midscale(blue_mid));
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) prev <= sin;
  always @(posedge core_clk) begin
    #1;
    pixel_tick = ~pixel_tick;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic clk_bit(input logic b, output logic s);
    tb_low = !b;
    cyc(4);
    scl = 1;
    cyc(4);
    s = sda;
    scl = 0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic ack;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
    clk_bit(1'b1, ack);
    if (last) cmp({7'h00, ack}, 8'h00);
  endtask
  task automatic start;
    tb_low = 0;
    cyc(4);
    scl = 1;
    cyc(4);
    tb_low = 1;
    cyc(4);
    scl = 0;
  endtask
  task automatic stop;
    tb_low = 1;
    cyc(4);
    scl = 1;
    cyc(4);
    tb_low = 0;
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start;
    xfer({`SERIAL_DEV_ADDR, 1'b0}, 1, q);
    xfer(a, 1, q);
    xfer(d, 1, q);
    stop;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    start;
    xfer({`SERIAL_DEV_ADDR, 1'b0}, 1, q);
    xfer(a, 1, q);
    start;
    xfer({`SERIAL_DEV_ADDR, 1'b1}, 1, q);
    xfer(8'hFF, 0, q);
    stop;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults;
    logic [7:0] q;
    logic [7:0] exp [4] = '{8'h40, 8'h4E, 8'h78, 8'h20};
    for (int i = 0; i < 4; i++) begin
      rd(8'h0E + 8'(i), q);
      cmp(q, exp[i]);
    end
    cmp({3'h0, slicer}, 8'h0F);
    cmp({4'h0, l_oe, f_oe, s_oe, p_oe}, 8'h0F);
    wr(8'h12, 8'h5A);
    rd(8'h12, q);
    cmp(q, 8'h00);
    $display("test defaults done");
  endtask
  task automatic t_line;
    logic [4:0] c;
    logic       act;
    for (int k = 0; k < 32; k++) begin
      c = 5'(k);
      wr(8'h0E, {2'b01, c[4:2], 3'b000});
      line_en = c[1];
      green_en = c[0];
      cyc(3);
      act = c[3] ? c[2] : (c[0] & !c[1]) ? 1'b1 : (c[1] & !c[0]) ? 1'b0 : c[2];
      cmp({7'h00, sout.active_line}, {7'h00, act});
      cmp({6'h00, sout.line_sync, sout.green_sync},
          {6'h00, (act ? prev.green : prev.line_pin) ^ c[4], prev.green ^ c[4]});
    end
    line_en = 0;
    green_en = 0;
    $display("test line done");
  endtask
  task automatic t_frame;
    logic [3:0] c;
    logic       act;
    for (int k = 0; k < 16; k++) begin
      c = 4'(k);
      wr(8'h0E, {5'b01000, c[1], c[3], c[2]});
      frame_det = c[0];
      frame_pin = ~frame_pin;
      cyc(3);
      act = c[3] ? c[2] : !c[0];
      cmp({6'h00, sout.active_frame, sout.frame_sync},
          {6'h00, act, (act ? 1'b0 : prev.frame_pin) ^ !c[1]});
    end
    frame_det = 0;
    $display("test frame done");
  endtask
  task automatic t_hold;
    logic [4:0] c;
    logic       eff;
    wr(8'h0E, 8'h46);
    for (int k = 0; k < 32; k++) begin
      c = 5'(k);
      wr(8'h0F, {2'b01, c[4:2], 3'b110});
      hold_pol_det = c[1];
      hold_pin = c[0];
      frame_pin = c[0];
      cyc(3);
      eff = c[3] ? c[2] : c[1];
      cmp({7'h00, sout.hold}, {7'h00, !(eff ^ c[0])});
    end
    $display("test hold done");
  endtask
  task automatic t_sep;
    wr(8'h11, 8'h02);
    wr(8'h0E, 8'h47);
    line_force = 1;
    cyc(40);
    cmp({7'h00, sout.frame_sync}, 8'h00);
    cyc(160);
    cmp({7'h00, sout.frame_sync}, 8'h01);
    $display("test separator done");
  endtask
  task automatic t_clamp;
    int n;
    int first;
    for (int k = 0; k < 4; k++) begin
      wr(8'h0F, {1'b1, k[1], 6'b001110});
      clamp_pin = k[0];
      cyc(3);
      cmp({7'h00, sout.clamp}, {7'h00, k[1] ^ k[0]});
    end
    wr(8'h0F, 8'h4E);
    line_force = 1;
    cyc(10);
    line_force = 0;
    n = 0;
    first = -1;
    for (int i = 0; i < 40; i++) begin
      cyc(1);
      if (sout.clamp === 1'b1) begin
        n++;
        if (first < 0) first = i;
      end
    end
    cmp(8'(n), 8'h06);
    cmp({7'h00, first >= 2 && first <= 9}, 8'h01);
    $display("test clamp done");
  endtask
  task automatic t_power;
    logic [7:0] q;
    wr(8'h0F, 8'h4C);
    cmp({3'h0, sout.sleep, l_oe, f_oe, s_oe, p_oe}, 8'h10);
    green_en = 1;
    cyc(3);
    cmp({7'h00, sout.green_sync}, {7'h00, prev.green});
    rd(8'h0F, q);
    cmp(q, 8'h4C);
    green_en = 0;
    cyc(3);
    cmp({7'h00, sout.seek}, 8'h01);
    green_en = 1;
    cyc(3);
    cmp({7'h00, sout.seek}, 8'h00);
    green_en = 0;
    wr(8'h0F, 8'h48);
    cmp({7'h00, sout.seek}, 8'h00);
    wr(8'h0F, 8'h4E);
    cmp({3'h0, sout.sleep, l_oe, f_oe, s_oe, p_oe}, 8'h0F);
    $display("test power done");
  endtask
  task automatic t_slicer;
    logic [7:0] v;
    logic [7:0] q;
    for (int k = 0; k < 4; k++) begin
      v = {(k[0] ? 5'h1F : 5'h01), k[1], k[0], 1'b0};
      wr(8'h10, v);
      cmp({slicer, red_mid, blue_mid, 1'b0}, v);
      rd(8'h10, q);
      cmp(q, v);
    end
    $display("test slicer done");
  endtask
  task automatic t_reset;
    nrst = 0;
    cyc(16);
    nrst = 1;
    cyc(1);
  endtask
  task automatic summarize;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 0;
    scl = 1;
    tb_low = 0;
    pixel_tick = 0;
    line_en = 0;
    green_en = 0;
    line_force = 0;
    frame_pin = 0;
    frame_det = 0;
    clamp_pin = 0;
    hold_pin = 0;
    hold_pol_det = 0;
    placement = 8'h02;
    duration = 8'h03;
    t_reset;
    t_defaults;
    t_line;
    t_frame;
    t_hold;
    t_sep;
    t_clamp;
    t_power;
    t_slicer;
    t_reset;
    t_defaults;
    summarize;
  end
  initial begin
    #200000;
    fails++;
    summarize;
  end
endmodule
bind sync_clamp_hold_control sync_ctl_monitor u_mon (.core_clk, .nrst, .sda_out, .sda_oe,
  .sync_in, .sync_out, .line_sync_output_oe, .frame_sync_output_oe, .sample_clock_output_oe,
  .pixel_data_oe, .slicer_threshold, .red_midscale, .blue_midscale);
